// ===== logic/vip_input_cfg.sv
`default_nettype none

// How it works
// - Mode field bits 6:4 of register 0x01 selects SD, HD, dual, simultaneous or ED54.
// - After reset the mode is SD only, code 000.
// - SD 8/10-bit 4:2:2 takes interleaved data from sd bus, or luma when swapped.
// - SD 16/20-bit: Y sd, CrCb luma; swapped: Y luma, CrCb chroma.
// - SD RGB: red sd bus, green luma bus, blue chroma bus.
// - SD YCrCb format comes from bits 4:3 of register 0x88.
// - Narrow widths use only the upper eight bits of each bus.
// - Bit 2 of register 0x33 picks 8-bit or 10-bit HD buses.
// - Bit 4 of register 0x88 picks 8-bit or 10-bit SD bus.
// - HD-only single rate YCrCb: bit 6 of 0x33 picks 4:2:2 or 4:4:4.
// - HD RGB only single rate 4:4:4; dual rate only 4:2:2 YCrCb.
// - HD single rate 4:2:2: Y from luma bus, CrCb from chroma bus.
// - Dual rate: Y and CrCb share luma bus on opposite clock edges.
module vip_input_cfg (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        primary_pixel_clock_in,
   input  wire logic        secondary_pixel_clock_in,
   input  wire logic [9:0]  sd_bus,
   input  wire logic [9:0]  luma_bus,
   input  wire logic [9:0]  chroma_bus,
   input  wire logic        sd_hsync_n,
   input  wire logic        sd_vsync_n,
   input  wire logic        prog_hsync_n,
   input  wire logic        prog_vsync_n,
   input  wire logic        prog_blank_n,
   output logic             sd_valid,
   output logic      [9:0]  sd_a,
   output logic      [9:0]  sd_b,
   output logic      [9:0]  sd_c,
   output logic      [1:0]  sd_sync_n,
   output logic             hd_valid,
   output logic      [9:0]  hd_a,
   output logic      [9:0]  hd_b,
   output logic      [9:0]  hd_c,
   output logic      [2:0]  hd_sync_n
);

   logic [7:0]  mode_ff;
   logic [7:0]  hd_cfg_ff;
   logic [7:0]  hd_rgb_ff;
   logic [7:0]  sd_rgb_ff;
   logic [7:0]  sd_cfg_ff;
   logic [31:0] prdata_ff;
   logic        slverr_ff;
   logic [36:0] s_all;
   logic        s_ck_a;
   logic        s_ck_b;
   logic [9:0]  s_sd;
   logic [9:0]  s_luma;
   logic [9:0]  s_chroma;
   logic [4:0]  s_syn;
   logic        ck_a_d_ff;
   logic        ck_b_d_ff;
   logic        sd_valid_ff;
   logic        hd_valid_ff;
   logic [1:0]  sd_sync_ff;
   logic [2:0]  hd_sync_ff;
   logic [9:0]  lane_in  [6];
   logic [9:0]  lane_out [6];
   logic [5:0]  lane_en;
   logic [5:0]  lane_wide;

   // Pins and both pixel clocks are sampled by pclk through two flip-flops.
   vip_sync #(.W(37)) u_sync (
      .clk   (pclk),
      .rst_n (presetn),
      .din   ({primary_pixel_clock_in, secondary_pixel_clock_in, sd_bus, luma_bus,
               chroma_bus, sd_hsync_n, sd_vsync_n, prog_hsync_n, prog_vsync_n,
               prog_blank_n}),
      .dout  (s_all)
   );
   assign {s_ck_a, s_ck_b, s_sd, s_luma, s_chroma, s_syn} = s_all;

   // Register bus decode; registers sit at four times their index.
   logic [7:0] idx;
   logic       idx_ok;
   logic       hit;
   logic       wr;
   assign idx    = paddr[9:2];
   assign idx_ok = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);
   assign hit    = idx_ok && (idx == vip_pkg::IDX_MODE || idx == vip_pkg::IDX_HD_CFG ||
                              idx == vip_pkg::IDX_HD_RGB || idx == vip_pkg::IDX_SD_RGB ||
                              idx == vip_pkg::IDX_SD_CFG || idx == vip_pkg::IDX_STATUS);
   assign wr     = psel && penable && pwrite && pstrb[0] && hit;
   assign pready = psel && penable;
   assign prdata = prdata_ff;
   assign pslverr = slverr_ff && pready;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_ff   <= vip_pkg::RST_MODE;
         hd_cfg_ff <= vip_pkg::RST_HD_CFG;
         hd_rgb_ff <= vip_pkg::RST_HD_RGB;
         sd_rgb_ff <= vip_pkg::RST_SD_RGB;
         sd_cfg_ff <= vip_pkg::RST_SD_CFG;
      end else if (wr) begin
         unique case (idx)
            vip_pkg::IDX_MODE:   mode_ff   <= pwdata[7:0] & vip_pkg::MASK_MODE;
            vip_pkg::IDX_HD_CFG: hd_cfg_ff <= pwdata[7:0] & vip_pkg::MASK_HD_CFG;
            vip_pkg::IDX_HD_RGB: hd_rgb_ff <= pwdata[7:0] & vip_pkg::MASK_HD_RGB;
            vip_pkg::IDX_SD_RGB: sd_rgb_ff <= pwdata[7:0] & vip_pkg::MASK_SD_RGB;
            vip_pkg::IDX_SD_CFG: sd_cfg_ff <= pwdata[7:0] & vip_pkg::MASK_SD_CFG;
            default: ;
         endcase
      end
   end

   // Mode decode.
   logic [2:0] mode;
   logic       swap;
   logic       y_on_fall;
   logic       sd_rgb;
   logic       sd_w16;
   logic       sd_wide;
   logic       hd_rgb;
   logic       hd_422;
   logic       hd_wide;
   logic       m_sd;
   logic       m_hd_sdr;
   logic       m_sim_sdr;
   logic       m_ed54;
   logic       ddr;
   logic       sd_act;
   logic       hd_act;
   logic       reserved;
   logic       sim;
   assign mode      = mode_ff[vip_pkg::MODE_LSB +: 3];
   assign swap      = mode_ff[vip_pkg::MODE_SWAP_BIT];
   assign y_on_fall = |mode_ff[vip_pkg::EDGE_LSB +: 2];
   assign sd_rgb    = sd_rgb_ff[vip_pkg::SD_RGB_BIT];
   assign sd_w16    = sd_cfg_ff[vip_pkg::SD_W16_BIT];
   assign sd_wide   = sd_cfg_ff[vip_pkg::SD_WIDE_BIT];
   assign hd_rgb    = hd_rgb_ff[vip_pkg::HD_RGB_BIT];
   assign hd_422    = hd_cfg_ff[vip_pkg::HD_FMT422_BIT];
   assign hd_wide   = hd_cfg_ff[vip_pkg::HD_WIDE_BIT];
   assign m_sd      = mode == vip_pkg::MODE_SD;
   assign m_hd_sdr  = mode == vip_pkg::MODE_HD_SDR;
   assign m_sim_sdr = mode == vip_pkg::MODE_SIM_SDR;
   assign m_ed54    = mode == vip_pkg::MODE_ED54;
   assign ddr       = mode == vip_pkg::MODE_HD_DDR || mode == vip_pkg::MODE_SIM_DDR;
   assign sim       = m_sim_sdr || mode == vip_pkg::MODE_SIM_DDR;
   assign sd_act    = m_sd || sim;
   assign hd_act    = m_hd_sdr || ddr || m_sim_sdr || m_ed54;
   assign reserved  = !sd_act && !hd_act;

   // Edges of the sampled pixel clocks.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ck_a_d_ff <= 1'b0;
         ck_b_d_ff <= 1'b0;
      end else begin
         ck_a_d_ff <= s_ck_a;
         ck_b_d_ff <= s_ck_b;
      end
   end

   logic rise_a;
   logic hd_rise;
   logic hd_fall;
   logic y_edge;
   logic c_edge;
   assign rise_a  = s_ck_a && !ck_a_d_ff;
   // HD-only modes clock on the primary pin, simultaneous modes on the secondary.
   assign hd_rise = sim ? (s_ck_b && !ck_b_d_ff) : rise_a;
   assign hd_fall = sim ? (!s_ck_b && ck_b_d_ff) : (!s_ck_a && ck_a_d_ff);
   assign y_edge  = y_on_fall ? hd_fall : hd_rise;
   assign c_edge  = y_on_fall ? hd_rise : hd_fall;

   // Lanes 0..2 carry the SD stream, lanes 3..5 the HD stream.
   always_comb begin
      lane_in[0] = s_sd;
      lane_in[1] = 10'h000;
      lane_in[2] = 10'h000;
      if (m_sd && sd_rgb) begin
         lane_in[0] = s_luma;
         lane_in[1] = s_sd;
         lane_in[2] = s_chroma;
      end else if (m_sd && sd_w16) begin
         lane_in[0] = swap ? s_luma : s_sd;
         lane_in[1] = swap ? s_chroma : s_luma;
      end else if (m_sd) begin
         lane_in[0] = swap ? s_luma : s_sd;
      end
      lane_in[3] = s_luma;
      lane_in[4] = s_chroma;
      lane_in[5] = 10'h000;
      if (ddr) begin
         lane_in[4] = s_luma;
      end else if (m_hd_sdr && (hd_rgb || !hd_422)) begin
         lane_in[4] = s_sd;
         lane_in[5] = s_chroma;
      end else if (m_ed54) begin
         lane_in[4] = 10'h000;
      end
   end

   // The RGB enable is ignored outside single-rate HD-only, so DDR stays 4:2:2.
   assign lane_en[2:0] = {3{sd_act && rise_a}};
   assign lane_en[3] = hd_act && (ddr ? y_edge : hd_rise);
   assign lane_en[4] = hd_act && (ddr ? c_edge : hd_rise);
   assign lane_en[5] = hd_act && !ddr && hd_rise;
   assign lane_wide  = {{3{hd_wide}}, {3{sd_wide}}};

   for (genvar g = 0; g < 6; g++) begin : g_lane
      vip_lane #(.W(10)) u_lane (
         .clk   (pclk),
         .rst_n (presetn),
         .en    (lane_en[g]),
         .wide  (lane_wide[g]),
         .din   (lane_in[g]),
         .dout  (lane_out[g])
      );
   end

   // Valid pulses and the sync levels that travel with each word.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sd_valid_ff <= 1'b0;
         hd_valid_ff <= 1'b0;
      end else begin
         sd_valid_ff <= sd_act && rise_a;
         hd_valid_ff <= hd_act && (ddr ? c_edge : hd_rise);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sd_sync_ff <= vip_pkg::RST_SD_SYNC;
         hd_sync_ff <= vip_pkg::RST_HD_SYNC;
      end else begin
         if (sd_act && rise_a) begin
            sd_sync_ff <= s_syn[4:3];
         end
         if (hd_act && hd_rise) begin
            hd_sync_ff <= s_syn[2:0];
         end
      end
   end

   assign sd_valid  = sd_valid_ff;
   assign hd_valid  = hd_valid_ff;
   assign sd_a      = lane_out[0];
   assign sd_b      = lane_out[1];
   assign sd_c      = lane_out[2];
   assign hd_a      = lane_out[3];
   assign hd_b      = lane_out[4];
   assign hd_c      = lane_out[5];
   assign sd_sync_n = sd_sync_ff;
   assign hd_sync_n = hd_sync_ff;

   // Status: mode, reserved mode, refused RGB enable, active streams.
   logic [7:0] status;
   assign status = {1'b0, hd_act, sd_act, hd_rgb && !m_hd_sdr, reserved, 1'b0, 1'b0, 1'b0} |
                   {5'h00, mode};

   // Read data is latched in the setup phase and held through the access phase.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_ff <= 32'h0000_0000;
         slverr_ff <= 1'b0;
      end else if (psel && !penable) begin
         slverr_ff <= !hit;
         prdata_ff <= 32'h0000_0000;
         if (hit && !pwrite) begin
            unique case (idx)
               vip_pkg::IDX_MODE:   prdata_ff <= {24'h000000, mode_ff};
               vip_pkg::IDX_HD_CFG: prdata_ff <= {24'h000000, hd_cfg_ff};
               vip_pkg::IDX_HD_RGB: prdata_ff <= {24'h000000, hd_rgb_ff};
               vip_pkg::IDX_SD_RGB: prdata_ff <= {24'h000000, sd_rgb_ff};
               vip_pkg::IDX_SD_CFG: prdata_ff <= {24'h000000, sd_cfg_ff};
               default:             prdata_ff <= {24'h000000, status};
            endcase
         end
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence seq_ddr_crcb;
      ddr && c_edge && hd_wide && hd_act;
   endsequence
   sequence seq_hd_422;
      m_hd_sdr && hd_422 && !hd_rgb && hd_rise && hd_wide;
   endsequence
   AST_MODE_WRITE_ONLY: assert property (
      $changed(mode_ff) |-> $past(wr && idx == vip_pkg::IDX_MODE))
      else $error("mode changed without a register write");
   AST_RESERVED_IDLE: assert property (
      reserved |=> !sd_valid && !hd_valid)
      else $error("reserved mode produced a pixel");
   AST_SD_INTERLEAVED: assert property (
      m_sd && !sd_rgb && !sd_w16 && sd_wide && rise_a
      |=> sd_valid && sd_a == (swap ? $past(s_luma) : $past(s_sd)))
      else $error("SD interleaved word taken from the wrong bus");
   AST_SD_WIDE422: assert property (
      m_sd && !sd_rgb && sd_w16 && sd_wide && rise_a
      |=> sd_b == (swap ? $past(s_chroma) : $past(s_luma)))
      else $error("SD CrCb taken from the wrong bus");
   AST_SD_RGB: assert property (
      m_sd && sd_rgb && sd_wide && rise_a
      |=> sd_b == $past(s_sd) && sd_a == $past(s_luma) && sd_c == $past(s_chroma))
      else $error("SD RGB components misrouted");
   AST_SD_NARROW: assert property (
      sd_act && rise_a && !sd_wide |=> sd_a[1:0] == 2'h0 && sd_b[1:0] == 2'h0)
      else $error("narrow SD bus kept its low bits");
   AST_HD_NARROW: assert property (
      hd_act && hd_rise && !hd_wide && !ddr |=> hd_a[1:0] == 2'h0 && hd_c[1:0] == 2'h0)
      else $error("narrow HD bus kept its low bits");
   AST_HD_444: assert property (
      m_hd_sdr && !hd_422 && hd_rise && hd_wide
      |=> hd_b == $past(s_sd) && hd_c == $past(s_chroma) && hd_a == $past(s_luma))
      else $error("HD 4:4:4 components misrouted");
   AST_HD_422: assert property (
      seq_hd_422 |=> hd_valid ##0 hd_a == $past(s_luma) && hd_b == $past(s_chroma))
      else $error("HD 4:2:2 components misrouted");
   AST_DDR_CRCB: assert property (
      seq_ddr_crcb |=> hd_valid && hd_b == $past(s_luma) && hd_c == 10'h000)
      else $error("dual rate CrCb not taken from luma bus");

endmodule : vip_input_cfg

`default_nettype wire

// ===== logic/vip_pkg.sv
`default_nettype none

package vip_pkg;

   // Register indices; the byte address of a register is its index times four.
   localparam int unsigned IDX_TO_BYTE = 4;
   localparam logic [7:0]  IDX_MODE    = 8'h01;
   localparam logic [7:0]  IDX_HD_CFG  = 8'h33;
   localparam logic [7:0]  IDX_HD_RGB  = 8'h35;
   localparam logic [7:0]  IDX_SD_RGB  = 8'h87;
   localparam logic [7:0]  IDX_SD_CFG  = 8'h88;
   localparam logic [7:0]  IDX_STATUS  = 8'h40;

   // Field positions.
   localparam int unsigned MODE_SWAP_BIT = 7;
   localparam int unsigned MODE_LSB      = 4;
   localparam int unsigned EDGE_LSB      = 1;
   localparam int unsigned HD_FMT422_BIT = 6;
   localparam int unsigned HD_WIDE_BIT   = 2;
   localparam int unsigned HD_RGB_BIT    = 1;
   localparam int unsigned SD_RGB_BIT    = 7;
   localparam int unsigned SD_W16_BIT    = 3;
   localparam int unsigned SD_WIDE_BIT   = 4;

   // Writable bits of each register; all other bits read as zero.
   localparam logic [7:0] MASK_MODE   = 8'hf6;
   localparam logic [7:0] MASK_HD_CFG = 8'h44;
   localparam logic [7:0] MASK_HD_RGB = 8'h02;
   localparam logic [7:0] MASK_SD_RGB = 8'h80;
   localparam logic [7:0] MASK_SD_CFG = 8'h18;

   // Values after reset.
   localparam logic [7:0] RST_MODE   = 8'h00;
   localparam logic [7:0] RST_HD_CFG = 8'h00;
   localparam logic [7:0] RST_HD_RGB = 8'h00;
   localparam logic [7:0] RST_SD_RGB = 8'h00;
   localparam logic [7:0] RST_SD_CFG = 8'h00;
   localparam logic [1:0] RST_SD_SYNC = 2'h3;
   localparam logic [2:0] RST_HD_SYNC = 3'h7;

   // Input mode codes.
   localparam logic [2:0] MODE_SD      = 3'h0;
   localparam logic [2:0] MODE_HD_SDR  = 3'h1;
   localparam logic [2:0] MODE_HD_DDR  = 3'h2;
   localparam logic [2:0] MODE_SIM_SDR = 3'h3;
   localparam logic [2:0] MODE_SIM_DDR = 3'h4;
   localparam logic [2:0] MODE_ED54    = 3'h7;

endpackage : vip_pkg

`default_nettype wire

// ===== logic/vip_sync.sv
`default_nettype none

module vip_sync #(
   parameter int unsigned W = 1
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);

   logic [W-1:0] meta_ff;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_ff <= '0;
         dout    <= '0;
      end else begin
         meta_ff <= din;
         dout    <= meta_ff;
      end
   end

endmodule : vip_sync

`default_nettype wire

// ===== logic/vip_lane.sv
`default_nettype none

module vip_lane #(
   parameter int unsigned W = 10
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic         en,
   input  wire logic         wide,
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);

   // A narrow bus keeps only its upper eight bits.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dout <= '0;
      end else if (en) begin
         dout <= wide ? din : {din[W-1:2], 2'b00};
      end
   end

endmodule : vip_lane

`default_nettype wire

// ===== bench/vip_src.sv
`default_nettype none

module vip_src (
   input  wire logic       run,
   input  wire logic [9:0] s_in,
   input  wire logic [9:0] y_in,
   input  wire logic [9:0] y2_in,
   input  wire logic [9:0] c_in,
   output logic            px_clk,
   output logic      [9:0] sd_bus,
   output logic      [9:0] luma_bus,
   output logic      [9:0] chroma_bus,
   output logic            sd_hsync_n,
   output logic            sd_vsync_n,
   output logic            prog_hsync_n,
   output logic            prog_vsync_n,
   output logic            prog_blank_n
);
   timeunit 1ns;
   timeprecision 1ns;

   logic to_fall;

   // The pixel clock only runs within a frame and has no phase tie to the system clock.
   initial begin
      px_clk = 1'b0;
      to_fall = 1'b0;
      #7;
      forever begin
         #40;
         to_fall = px_clk;
         #40;
         px_clk = run ? ~px_clk : 1'b0;
      end
   end

   // Released buses show the inverse of the last word so stale data is never taken.
   assign sd_bus = run ? s_in : ~s_in;
   assign luma_bus = run ? (to_fall ? y2_in : y_in) : ~y_in;
   assign chroma_bus = run ? c_in : ~c_in;
   assign sd_hsync_n = ~run;
   assign sd_vsync_n = 1'b1;
   assign prog_hsync_n = ~run;
   assign prog_vsync_n = 1'b1;
   assign prog_blank_n = 1'b1;

endmodule : vip_src

`default_nettype wire

// ===== bench/video_input_port_config_tb.sv
`default_nettype none

`define CHECK(nm, ex, gt) begin checks++; if ((gt) !== (ex)) begin errors++; $display("wrong value %s expected %h seen %h", nm, ex, gt); end end

module video_input_port_config_tb;
   timeunit 1ns;
   timeprecision 1ns;

   typedef struct packed {
      logic [7:0]  md;
      logic [7:0]  hc;
      logic [7:0]  hr;
      logic [7:0]  sr;
      logic [7:0]  sc;
      logic [11:0] sel;
   } vip_case_type;

   localparam logic [9:0] SV  = 10'h2a5;
   localparam logic [9:0] YV  = 10'h15a;
   localparam logic [9:0] Y2V = 10'h36b;
   localparam logic [9:0] CV  = 10'h0f3;
   localparam logic [7:0] IDX [5] = '{vip_pkg::IDX_MODE, vip_pkg::IDX_HD_CFG,
      vip_pkg::IDX_HD_RGB, vip_pkg::IDX_SD_RGB, vip_pkg::IDX_SD_CFG};
   localparam logic [7:0] MSK [5] = '{vip_pkg::MASK_MODE, vip_pkg::MASK_HD_CFG,
      vip_pkg::MASK_HD_RGB, vip_pkg::MASK_SD_RGB, vip_pkg::MASK_SD_CFG};
   // Output sources per field, sd a/b/c then hd a/b/c: 0 sd bus, 1 luma, 2 chroma or late luma, 3 none.
   localparam vip_case_type CASES [17] = '{
      '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 12'h3ff},
      '{8'h80, 8'h00, 8'h00, 8'h00, 8'h10, 12'h7ff},
      '{8'h00, 8'h00, 8'h00, 8'h00, 8'h08, 12'h1ff},
      '{8'h80, 8'h00, 8'h00, 8'h00, 8'h18, 12'h6ff},
      '{8'h00, 8'h00, 8'h00, 8'h80, 8'h10, 12'h4bf},
      '{8'h00, 8'h00, 8'h00, 8'h80, 8'h00, 12'h4bf},
      '{8'h10, 8'h44, 8'h00, 8'h00, 8'h00, 12'hfdb},
      '{8'h10, 8'h00, 8'h00, 8'h00, 8'h00, 12'hfd2},
      '{8'h10, 8'h04, 8'h02, 8'h00, 8'h00, 12'hfd2},
      '{8'h70, 8'h04, 8'h00, 8'h00, 8'h00, 12'hfdf},
      '{8'h30, 8'h44, 8'h00, 8'h00, 8'h10, 12'h3db},
      '{8'h20, 8'h04, 8'h00, 8'h00, 8'h00, 12'hfdb},
      '{8'h22, 8'h04, 8'h00, 8'h00, 8'h00, 12'hfe7},
      '{8'h40, 8'h04, 8'h00, 8'h00, 8'h10, 12'h3db},
      '{8'h50, 8'h00, 8'h00, 8'h00, 8'h00, 12'hfff},
      '{8'h60, 8'h00, 8'h00, 8'h00, 8'h00, 12'hfff},
      '{8'h00, 8'h00, 8'h02, 8'h00, 8'h00, 12'h3ff}
   };

   int          errors = 0;
   int          checks = 0;
   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [3:0]  pstrb;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [31:0] rd;
   logic        er;
   logic        run;
   logic        ddr;
   logic [9:0]  y2;
   logic        px_clk;
   logic [9:0]  sd_bus;
   logic [9:0]  luma_bus;
   logic [9:0]  chroma_bus;
   logic        sd_hsync_n;
   logic        sd_vsync_n;
   logic        prog_hsync_n;
   logic        prog_vsync_n;
   logic        prog_blank_n;
   logic        sd_valid;
   logic        hd_valid;
   logic [9:0]  sd_a;
   logic [9:0]  sd_b;
   logic [9:0]  sd_c;
   logic [9:0]  hd_a;
   logic [9:0]  hd_b;
   logic [9:0]  hd_c;
   logic [1:0]  sd_sync_n;
   logic [2:0]  hd_sync_n;

   vip_input_cfg i_vip_input_cfg (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
      .pready, .pslverr, .primary_pixel_clock_in(px_clk), .secondary_pixel_clock_in(px_clk),
      .sd_bus, .luma_bus, .chroma_bus, .sd_hsync_n, .sd_vsync_n, .prog_hsync_n,
      .prog_vsync_n, .prog_blank_n, .sd_valid, .sd_a, .sd_b, .sd_c, .sd_sync_n,
      .hd_valid, .hd_a, .hd_b, .hd_c, .hd_sync_n
   );

   vip_src i_vip_src (
      .run, .s_in(SV), .y_in(YV), .y2_in(y2), .c_in(CV), .px_clk, .sd_bus, .luma_bus,
      .chroma_bus, .sd_hsync_n, .sd_vsync_n, .prog_hsync_n, .prog_vsync_n, .prog_blank_n
   );

   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end

   function automatic logic [9:0] src(input logic [1:0] k, input logic nar);
      logic [9:0] v;
      v = (k == 2'd0) ? SV : (k == 2'd1) ? YV : ddr ? Y2V : CV;
      return nar ? (v & 10'h3fc) : v;
   endfunction : src

   task automatic give_verdict();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : give_verdict

   task automatic reset_dut();
      presetn <= 1'b0;
      run <= 1'b0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
   endtask : reset_dut

   task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] wd);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= {2'b00, idx, 2'b00};
      pwdata <= wd;
      pstrb <= 4'hf;
      @(posedge pclk);
      penable <= 1'b1;
      // Only the watchdog ends a wait for an answer that never comes.
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb

   task automatic run_case(input vip_case_type cs);
      int nsd;
      int nhd;
      int esd;
      int ehd;
      int n;
      logic [5:0][9:0] got;
      logic [1:0] sdy;
      logic [2:0] hdy;
      reset_dut();
      ddr = (cs.md[6:4] == 3'h2) || (cs.md[6:4] == 3'h4);
      for (int k = 0; k < 5; k++) apb(1'b1, IDX[k], {24'h0, cs[51-8*k -: 8]});
      esd = (cs.sel[11:6] != 6'h3f) ? 1 : 0;
      ehd = (cs.sel[5:0] == 6'h3f) ? 0 : (ddr && cs.md[2:1] != 2'b00) ? 2 : 1;
      nsd = 0;
      nhd = 0;
      n = 0;
      y2 <= ddr ? Y2V : YV;
      run <= 1'b1;
      while ((nsd < esd || nhd < ehd || esd + ehd == 0) && n < 40) begin
         @(posedge pclk);
         n++;
         if (sd_valid === 1'b1) begin
            nsd++;
            {got[0], got[1], got[2], sdy} = {sd_a, sd_b, sd_c, sd_sync_n};
         end
         if (hd_valid === 1'b1) begin
            nhd++;
            {got[3], got[4], got[5], hdy} = {hd_a, hd_b, hd_c, hd_sync_n};
         end
      end
      run <= 1'b0;
      `CHECK("sd words", esd, nsd)
      `CHECK("hd words", ehd, nhd)
      if (esd > 0) `CHECK("sd sync", 2'b01, sdy)
      if (ehd > 0) `CHECK("hd sync", 3'b011, hdy)
      for (int k = 0; k < 6; k++) begin
         if (cs.sel[11-2*k -: 2] != 2'd3) begin
            `CHECK("pixel", src(cs.sel[11-2*k -: 2], k < 3 ? !cs.sc[4] : !cs.hc[2]), got[k])
         end
      end
   endtask : run_case

   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      pstrb = 4'h0;
      run = 1'b0;
      ddr = 1'b0;
      y2 = YV;
      reset_dut();
      for (int k = 0; k < 5; k++) begin
         apb(1'b0, IDX[k], 32'h0);
         `CHECK("reset value", 32'h0, rd)
         apb(1'b1, IDX[k], 32'hffffffff);
         apb(1'b0, IDX[k], 32'h0);
         `CHECK("register", {24'h0, MSK[k]}, rd)
      end
      apb(1'b0, vip_pkg::IDX_STATUS, 32'h0);
      `CHECK("status", 8'h57, rd[7:0])
      apb(1'b0, 8'h02, 32'h0);
      `CHECK("slave error", 1'b1, er)
      for (int i = 0; i < 17; i++) run_case(CASES[i]);
      give_verdict();
   end

   // The whole run needs under 15 us; this cuts a hang short.
   initial begin
      #100000;
      errors++;
      give_verdict();
   end

endmodule : video_input_port_config_tb

`default_nettype wire
